// ---- rtl/dsc_conv_ctl.sv ----
// conversion sequencer for a dual simultaneous-sampling 12-bit converter
// assumes host pins are asynchronous to CLOCK_I and the external clock is slow
//
// How it works
// - conversion start rising edge puts both sample-and-hold stages into hold together.
// - successive approximation begins on the next external clock rising edge.
// - joined strobe changes on rising edge; sampled falling, conversion follows next rise.
// - twelve clocks convert, one pre-charges, three of sixteen remain for sampling.
// - after conversion capacitors pre-charge one clock, then reconnect to multiplexer.
// - busy stays low through acquisition until the next conversion start edge.
// - fully differential: code 00 pair zero, code 11 pair one.
// - pseudo-differential: pair zero negative common; 00, 01, 11 pick positive input.
// - both converters sample and convert from the same start and clock.
// - ten-bit reference DAC code programmed over the serial interface.
// - DAC code comes up at the nominal reference value without programming.
// - reference power-down bit switches the internal reference off.
// - power-on reset resets the whole block; reset action code resets all of it but the input synchronisers.
// - busy rises on entering hold, falls when conversion finishes.
// - twelve-bit word, msb first on falling edges, reset value zero.
// - new settings take effect on the twelfth rising edge after the strobe.
`default_nettype none

module dsc_conv_ctl
    import dsc_pkg::*;
(
    input wire logic CLOCK_I,
    input wire logic SYS_RST_I,
    input wire logic EXT_CLOCK_I,
    input wire logic CONVERSION_START_I,
    input wire logic READ_STROBE_I,
    input wire logic SERIAL_CONFIG_INPUT_I,
    input wire logic PSEUDO_DIFF_I,
    output logic BUSY_O,
    output logic HOLD_O,
    output logic PRECHARGE_O,
    output logic SAR_ACTIVE_O,
    output logic [3:0] SAR_BIT_O,
    output logic [1:0] MUX_POS_O,
    output logic MUX_NEG_O,
    output logic [9:0] DAC_CODE_O,
    output logic REFERENCE_OFF_O,
    output logic SOFT_RESET_O
);
    dsc_ctl_t st;
    dsc_ctl_t next_st;
    dsc_cfg_if cfg_bus ();

    dsc_cfg_shift u_shift (
        .clk_i(CLOCK_I),
        .rst_i(SYS_RST_I || st.soft_rst),
        .cfg(cfg_bus.cfg)
    );

    assign cfg_bus.clk_rise = st.clk_rise;
    assign cfg_bus.clk_fall = st.clk_fall;
    assign cfg_bus.serial_config_input = st.sdi_lvl;
    assign cfg_bus.strobe = st.rd_lvl;

    always_comb begin
        logic [2:0] mux;
        mux = 3'h0;
        next_st = st;
        next_st.clk_sync = {st.clk_sync[1:0], EXT_CLOCK_I};
        next_st.cs_sync = {st.cs_sync[1:0], CONVERSION_START_I};
        next_st.rd_sync = {st.rd_sync[1:0], READ_STROBE_I};
        next_st.sdi_sync = {st.sdi_sync[1:0], SERIAL_CONFIG_INPUT_I};
        next_st.pd_sync = {st.pd_sync[1:0], PSEUDO_DIFF_I};
        next_st.clk_lvl = sync_filt(st.clk_sync[1], st.clk_sync[2], st.clk_lvl);
        next_st.cs_lvl = sync_filt(st.cs_sync[1], st.cs_sync[2], st.cs_lvl);
        next_st.rd_lvl = sync_filt(st.rd_sync[1], st.rd_sync[2], st.rd_lvl);
        next_st.sdi_lvl = sync_filt(st.sdi_sync[1], st.sdi_sync[2], st.sdi_lvl);
        next_st.pd_lvl = sync_filt(st.pd_sync[1], st.pd_sync[2], st.pd_lvl);
        next_st.clk_rise = next_st.clk_lvl && !st.clk_lvl;
        next_st.clk_fall = !next_st.clk_lvl && st.clk_lvl;
        next_st.cs_rise = next_st.cs_lvl && !st.cs_lvl;

        case (st.phase)
            PH_ACQUIRE: begin
                if (st.cs_rise) begin
                    next_st.phase = PH_HOLD;
                    next_st.hold = 1'b1;
                    next_st.busy = 1'b1;
                end
            end
            PH_HOLD: begin
                if (st.clk_rise) begin
                    next_st.phase = PH_CONVERT;
                    next_st.sar_active = 1'b1;
                    next_st.sar_bit = SAR_MSB;
                    next_st.step = 4'h0;
                end
            end
            PH_CONVERT: begin
                if (st.clk_rise) begin
                    if (st.step == CONV_LAST) begin
                        next_st.phase = PH_PRECHARGE;
                        next_st.busy = 1'b0;
                        next_st.sar_active = 1'b0;
                        next_st.sar_bit = 4'h0;
                        next_st.precharge = 1'b1;
                    end else begin
                        next_st.step = st.step + 4'h1;
                        next_st.sar_bit = st.sar_bit - 4'h1;
                    end
                end
            end
            PH_PRECHARGE: begin
                if (st.clk_rise) begin
                    next_st.phase = PH_ACQUIRE;
                    next_st.precharge = 1'b0;
                    next_st.hold = 1'b0;
                end
            end
            default: begin
                next_st.phase = PH_ACQUIRE;
            end
        endcase

        next_st.soft_rst = 1'b0;
        if (cfg_bus.apply) begin
            if (st.dac_pending) begin
                next_st.dac_code = cfg_bus.word[DAC_BITS-1:0];
                next_st.dac_pending = 1'b0;
            end else begin
                next_st.ch_sel = {cfg_bus.word[CH_HI_POS], cfg_bus.word[CH_LO_POS]};
                next_st.ref_pd = cfg_bus.word[REF_PD_POS];
                case (cfg_bus.word[ACT_MSB:0])
                    ACT_DAC_WRITE: next_st.dac_pending = 1'b1;
                    ACT_RESET: next_st.soft_rst = 1'b1;
                    default: next_st.dac_pending = 1'b0;
                endcase
            end
        end

        if (st.soft_rst) begin
            next_st.phase = PH_ACQUIRE;
            next_st.step = 4'h0;
            next_st.busy = 1'b0;
            next_st.hold = 1'b0;
            next_st.precharge = 1'b0;
            next_st.sar_active = 1'b0;
            next_st.sar_bit = 4'h0;
            next_st.ch_sel = CFG_RESET[CH_HI_POS:CH_LO_POS];
            next_st.ref_pd = CFG_RESET[REF_PD_POS];
            next_st.dac_code = DAC_RESET;
            next_st.dac_pending = 1'b0;
        end

        mux = mux_decode(next_st.ch_sel, next_st.pd_lvl);
        next_st.mux_pos = mux[2:1];
        next_st.mux_neg = mux[0];
    end

    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            st <= CTL_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign BUSY_O = st.busy;
    assign HOLD_O = st.hold;
    assign PRECHARGE_O = st.precharge;
    assign SAR_ACTIVE_O = st.sar_active;
    assign SAR_BIT_O = st.sar_bit;
    assign MUX_POS_O = st.mux_pos;
    assign MUX_NEG_O = st.mux_neg;
    assign DAC_CODE_O = st.dac_code;
    assign REFERENCE_OFF_O = st.ref_pd;
    assign SOFT_RESET_O = st.soft_rst;

    default clocking dc @(posedge CLOCK_I);
    endclocking
    default disable iff (SYS_RST_I || st.soft_rst);

    a_hold_on_start: assert property (
        (st.phase == PH_ACQUIRE && st.cs_rise) |=> HOLD_O && BUSY_O && st.phase == PH_HOLD)
        else $error("start edge did not enter hold");
    a_conv_next_rise: assert property (
        $rose(SAR_ACTIVE_O) |-> $past(st.clk_rise) && $past(st.phase) == PH_HOLD
            && SAR_BIT_O == SAR_MSB)
        else $error("conversion began off the next rising edge");
    a_conv_twelve: assert property (
        $rose(PRECHARGE_O) |-> $past(st.step) == CONV_LAST && $past(st.clk_rise))
        else $error("conversion did not last twelve clocks");
    a_precharge_one: assert property (
        (PRECHARGE_O && st.clk_rise) |=> !PRECHARGE_O && !HOLD_O && st.phase == PH_ACQUIRE)
        else $error("pre-charge not ended on next rising edge");
    a_acq_busy_low: assert property (
        st.phase == PH_ACQUIRE |-> !BUSY_O && !HOLD_O)
        else $error("busy or hold during acquisition");
    a_busy_done: assert property (
        (st.phase == PH_CONVERT && st.clk_rise && st.step == CONV_LAST) |=> !BUSY_O)
        else $error("busy not cleared at end of conversion");
    a_mux_diff: assert property (
        (!st.pd_lvl && st.ch_sel == 2'h3) |-> MUX_POS_O == POS_P1P && MUX_NEG_O == NEG_P1N)
        else $error("differential pair one not selected");
    a_mux_pseudo: assert property (
        (st.pd_lvl && st.ch_sel == 2'h1) |-> MUX_POS_O == POS_P1N && MUX_NEG_O == NEG_P0N)
        else $error("pseudo-differential selection wrong");
    a_sar_held: assert property (
        SAR_ACTIVE_O |-> HOLD_O && BUSY_O)
        else $error("converting while not held");
    a_ref_pd: assert property (
        (cfg_bus.apply && !st.dac_pending) |=> REFERENCE_OFF_O == $past(cfg_bus.word[REF_PD_POS]))
        else $error("reference power-down not taken");
    a_reset_code: assert property (disable iff (SYS_RST_I)
        (cfg_bus.apply && !st.dac_pending && cfg_bus.word[ACT_MSB:0] == ACT_RESET)
            |=> st.soft_rst ##1 (DAC_CODE_O == DAC_RESET && !BUSY_O && st.ch_sel == 2'h0))
        else $error("reset code did not reset the block");
    a_dac_write: assert property (
        (cfg_bus.apply && st.dac_pending) |=> DAC_CODE_O == $past(cfg_bus.word[DAC_BITS-1:0]))
        else $error("dac code not written");

    c_full_cycle: cover property (st.phase == PH_PRECHARGE ##1 st.phase == PH_ACQUIRE);
    c_dac_written: cover property (cfg_bus.apply && st.dac_pending);
    c_pseudo_sel: cover property (st.pd_lvl && MUX_POS_O == POS_P1N);
    c_soft_reset: cover property (disable iff (SYS_RST_I) st.soft_rst);
endmodule

`default_nettype wire

// ---- inc/dsc_pkg.sv ----
// constants, state types and helpers for the dual converter control block
// assumes one 50 MHz system clock; all host pins arrive asynchronously
`default_nettype none

package dsc_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int CONV_CYCLES = 12;
    localparam int PRECHARGE_CYCLES = 1;
    localparam int MIN_PERIOD_CYCLES = 16;
    localparam int SAMPLE_CYCLES = MIN_PERIOD_CYCLES - CONV_CYCLES - PRECHARGE_CYCLES;
    localparam logic [3:0] CONV_LAST = 4'(CONV_CYCLES - 1);
    localparam logic [3:0] SAR_MSB = 4'h0b;

    localparam int CFG_BITS = 12;
    localparam logic [3:0] APPLY_LAST = 4'(CFG_BITS - 1);
    localparam logic [11:0] CFG_RESET = 12'h000;
    localparam int CH_HI_POS = 11;
    localparam int CH_LO_POS = 10;
    localparam int REF_PD_POS = 4;
    localparam int ACT_MSB = 2;
    localparam logic [2:0] ACT_DAC_WRITE = 3'h1;
    localparam logic [2:0] ACT_RESET = 3'h5;

    localparam int DAC_BITS = 10;
    localparam int DAC_STEP_UV = 2440;
    localparam int DAC_MIN_UV = 500_000;
    localparam logic [9:0] DAC_RESET = 10'h3ff;
    localparam logic [9:0] DAC_MIN_CODE = 10'((DAC_MIN_UV + DAC_STEP_UV - 1) / DAC_STEP_UV);

    localparam logic [1:0] POS_P0P = 2'h0;
    localparam logic [1:0] POS_P1N = 2'h1;
    localparam logic [1:0] POS_P1P = 2'h2;
    localparam logic NEG_P0N = 1'b0;
    localparam logic NEG_P1N = 1'b1;
    localparam logic [2:0] SYNC_RESET = 3'h0;

    typedef enum logic [1:0] {PH_ACQUIRE, PH_HOLD, PH_CONVERT, PH_PRECHARGE} dsc_phase_t;

    typedef struct packed {
        logic [2:0] clk_sync;
        logic [2:0] cs_sync;
        logic [2:0] rd_sync;
        logic [2:0] sdi_sync;
        logic [2:0] pd_sync;
        logic clk_lvl;
        logic cs_lvl;
        logic rd_lvl;
        logic sdi_lvl;
        logic pd_lvl;
        logic clk_rise;
        logic clk_fall;
        logic cs_rise;
        dsc_phase_t phase;
        logic [3:0] step;
        logic busy;
        logic hold;
        logic precharge;
        logic sar_active;
        logic [3:0] sar_bit;
        logic [1:0] ch_sel;
        logic ref_pd;
        logic [9:0] dac_code;
        logic dac_pending;
        logic soft_rst;
        logic [1:0] mux_pos;
        logic mux_neg;
    } dsc_ctl_t;

    typedef struct packed {
        logic active;
        logic [11:0] shift;
        logic [3:0] fall_cnt;
        logic [3:0] rise_cnt;
        logic apply;
        logic [11:0] word;
    } dsc_cfg_t;

    localparam dsc_ctl_t CTL_RESET = '{phase: PH_ACQUIRE, dac_code: DAC_RESET, default: '0};
    localparam dsc_cfg_t CFG_ST_RESET = '{word: CFG_RESET, default: '0};

    // level changes only once the last two stages agree
    function automatic logic sync_filt(input logic s2, input logic s3, input logic old);
        return (s2 == s3) ? s2 : old;
    endfunction

    // input multiplexer selection from channel code and wiring mode
    function automatic logic [2:0] mux_decode(input logic [1:0] ch, input logic pseudo);
        logic [1:0] pos;
        logic neg;
        pos = (ch == 2'h0) ? POS_P0P : ((ch == 2'h1) ? POS_P1N : POS_P1P);
        neg = (!pseudo && ch == 2'h3) ? NEG_P1N : NEG_P0N;
        return {pos, neg};
    endfunction
endpackage

`default_nettype wire

// ---- inc/dsc_cfg_if.sv ----
// signals between the sequencer and the serial configuration shifter
// assumes both ends run on the same system clock
`default_nettype none

interface dsc_cfg_if;
    logic clk_rise;
    logic clk_fall;
    logic serial_config_input;
    logic strobe;
    logic apply;
    logic [11:0] word;
    modport ctl (output clk_rise, output clk_fall, output serial_config_input, output strobe,
        input apply, input word);
    modport cfg (input clk_rise, input clk_fall, input serial_config_input, input strobe,
        output apply, output word);
endinterface

`default_nettype wire

// ---- rtl/dsc_cfg_shift.sv ----
// serial configuration shifter: 12-bit word, msb first, one apply pulse
// assumes edge pulses already synchronised by the sequencer
`default_nettype none

module dsc_cfg_shift
    import dsc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    dsc_cfg_if.cfg cfg
);
    dsc_cfg_t st;
    dsc_cfg_t next_st;

    always_comb begin
        next_st = st;
        next_st.apply = 1'b0;
        if (cfg.clk_fall && cfg.strobe) begin
            next_st.active = 1'b1;
            next_st.shift = {st.shift[10:0], cfg.serial_config_input};
            next_st.fall_cnt = 4'h1;
            next_st.rise_cnt = 4'h0;
        end else if (st.active && cfg.clk_fall && st.fall_cnt < 4'(CFG_BITS)) begin
            next_st.shift = {st.shift[10:0], cfg.serial_config_input};
            next_st.fall_cnt = st.fall_cnt + 4'h1;
        end
        if (st.active && cfg.clk_rise) begin
            if (st.rise_cnt == APPLY_LAST) begin
                next_st.apply = 1'b1;
                next_st.word = st.shift;
                next_st.active = 1'b0;
            end else begin
                next_st.rise_cnt = st.rise_cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= CFG_ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign cfg.apply = st.apply;
    assign cfg.word = st.word;

    a_apply_single: assert property (@(posedge clk_i) disable iff (rst_i)
        st.apply |=> !st.apply && !st.active)
        else $error("apply pulse longer than one cycle");
    a_apply_count: assert property (@(posedge clk_i) disable iff (rst_i)
        st.apply |-> $past(st.rise_cnt) == APPLY_LAST && $past(st.fall_cnt) == 4'(CFG_BITS))
        else $error("word applied before twelve bits");
    c_word_applied: cover property (@(posedge clk_i) disable iff (rst_i) st.apply);
endmodule

`default_nettype wire

// ---- testbench/dsc_host_model.sv ----
// host-side model: external clock, conversion start, read strobe, serial bits
// assumes clk_i is the 50 MHz system clock; each ext clock phase lasts 10 cycles
`default_nettype none

module dsc_host_model (
    input wire logic clk_i,
    output logic ext_clk_o,
    output logic conv_start_o,
    output logic read_strobe_o,
    output logic sdi_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        ext_clk_o = 1'b0;
        conv_start_o = 1'b0;
        read_strobe_o = 1'b0;
        sdi_o = 1'b0;
    end

    task automatic half();
        repeat (10) @(posedge clk_i);
        #1;
    endtask

    task automatic tick();
        ext_clk_o = 1'b1;
        half();
        ext_clk_o = 1'b0;
        half();
    endtask

    task automatic start_conv();
        conv_start_o = 1'b1;
        half();
        conv_start_o = 1'b0;
    endtask

    task automatic send_bits(input logic [11:0] word);
        for (int i = 11; i >= 0; i--) begin
            read_strobe_o = (i == 11);
            sdi_o = word[i];
            tick();
        end
        read_strobe_o = 1'b0;
        sdi_o = ~word[0];
    endtask
endmodule

`default_nettype wire

// ---- testbench/dsc_conv_ctl_tb.sv ----
// self-checking bench for the dual converter sequencer
// assumes host model drives the host pins; the bench drives mode pin and reset
`default_nettype none

module dsc_conv_ctl_tb
    import dsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk;
    logic rst;
    logic pseudo;
    logic ext_clk;
    logic conv_start;
    logic read_strobe;
    logic serial_config_input;
    logic busy;
    logic hold;
    logic precharge;
    logic sar_active;
    logic [3:0] sar_bit;
    logic [1:0] mux_pos;
    logic mux_neg;
    logic [9:0] dac_code;
    logic ref_off;
    logic soft_rst;
    logic sr_seen;
    int miscompares;
    int n_checks;
    int cycles;

    dsc_conv_ctl dsc_conv_ctl_i (
        .CLOCK_I(clk),
        .SYS_RST_I(rst),
        .EXT_CLOCK_I(ext_clk),
        .CONVERSION_START_I(conv_start),
        .READ_STROBE_I(read_strobe),
        .SERIAL_CONFIG_INPUT_I(serial_config_input),
        .PSEUDO_DIFF_I(pseudo),
        .BUSY_O(busy),
        .HOLD_O(hold),
        .PRECHARGE_O(precharge),
        .SAR_ACTIVE_O(sar_active),
        .SAR_BIT_O(sar_bit),
        .MUX_POS_O(mux_pos),
        .MUX_NEG_O(mux_neg),
        .DAC_CODE_O(dac_code),
        .REFERENCE_OFF_O(ref_off),
        .SOFT_RESET_O(soft_rst)
    );

    dsc_host_model dsc_host_model_i (
        .clk_i(clk),
        .ext_clk_o(ext_clk),
        .conv_start_o(conv_start),
        .read_strobe_o(read_strobe),
        .sdi_o(serial_config_input)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        if (soft_rst === 1'b1) sr_seen <= 1'b1;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic check_bit(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_vec(input string what, input logic [11:0] exp, input logic [11:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_reset();
        check_vec("dac_code", 12'h3ff, 12'(dac_code));
        check_bit("busy", 1'b0, busy);
        check_bit("ref_off", 1'b0, ref_off);
        check_vec("mux_pos", 12'h000, 12'(mux_pos));
        $display("test_reset done");
    endtask

    task automatic test_convert();
        int n_sar;
        int n_pre;
        n_sar = 1;
        n_pre = 0;
        repeat (3) dsc_host_model_i.tick();
        check_bit("busy", 1'b0, busy);
        check_bit("hold", 1'b0, hold);
        dsc_host_model_i.start_conv();
        check_bit("hold", 1'b1, hold);
        check_bit("busy", 1'b1, busy);
        check_bit("sar_active", 1'b0, sar_active);
        dsc_host_model_i.tick();
        check_vec("sar_bit", 12'h00b, 12'(sar_bit));
        repeat (20) begin
            dsc_host_model_i.tick();
            if (sar_active === 1'b1) n_sar++;
            if (precharge === 1'b1) n_pre++;
        end
        check_vec("convert ticks", 12'h00c, 12'(n_sar));
        check_vec("precharge ticks", 12'h001, 12'(n_pre));
        check_bit("busy", 1'b0, busy);
        check_bit("hold", 1'b0, hold);
        $display("test_convert done");
    endtask

    task automatic test_mux();
        logic [1:0] exp_pos;
        logic [1:0] prev_pos;
        logic exp_neg;
        prev_pos = 2'h0;
        for (int m = 0; m < 2; m++) begin
            for (int c = 0; c < 4; c++) begin
                pseudo = m[0];
                dsc_host_model_i.send_bits({c[1:0], 10'h000});
                check_vec("mux_pos early", 12'(prev_pos), 12'(mux_pos));
                dsc_host_model_i.tick();
                exp_pos = (c == 0) ? 2'h0 : ((c == 1) ? 2'h1 : 2'h2);
                exp_neg = (m == 0 && c == 3);
                check_vec("mux_pos", 12'(exp_pos), 12'(mux_pos));
                check_bit("mux_neg", exp_neg, mux_neg);
                prev_pos = exp_pos;
            end
        end
        $display("test_mux done");
    endtask

    task automatic test_ref();
        dsc_host_model_i.send_bits(12'h010);
        dsc_host_model_i.tick();
        check_bit("ref_off", 1'b1, ref_off);
        dsc_host_model_i.send_bits(12'h000);
        dsc_host_model_i.tick();
        check_bit("ref_off", 1'b0, ref_off);
        $display("test_ref done");
    endtask

    task automatic test_dac_reset();
        logic [2:0] idle_acts [5];
        idle_acts = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h7};
        dsc_host_model_i.send_bits({9'h000, ACT_DAC_WRITE});
        dsc_host_model_i.tick();
        dsc_host_model_i.send_bits(12'h155);
        dsc_host_model_i.tick();
        check_vec("dac_code", 12'h155, 12'(dac_code));
        foreach (idle_acts[k]) begin
            dsc_host_model_i.send_bits({9'h000, idle_acts[k]});
            dsc_host_model_i.tick();
            check_vec("dac_code", 12'h155, 12'(dac_code));
        end
        dsc_host_model_i.send_bits(12'hc10);
        dsc_host_model_i.tick();
        sr_seen = 1'b0;
        // reset word also sets channel 11 and power-down, so only the reset can clear them
        dsc_host_model_i.send_bits({9'h182, ACT_RESET});
        dsc_host_model_i.tick();
        check_bit("soft reset", 1'b1, sr_seen);
        check_vec("dac_code", 12'h3ff, 12'(dac_code));
        check_bit("ref_off", 1'b0, ref_off);
        check_vec("mux_pos", 12'h000, 12'(mux_pos));
        $display("test_dac_reset done");
    endtask

    initial begin
        rst = 1'b1;
        pseudo = 1'b0;
        sr_seen = 1'b0;
        miscompares = 0;
        n_checks = 0;
        cycles = 0;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        test_reset();
        test_convert();
        test_mux();
        test_ref();
        test_dac_reset();
        give_verdict();
    end
endmodule

`default_nettype wire
